// [bench/tb_pfc_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_pfc_regs;
    import pfc_pkg::*;

    localparam int unsigned LIMIT = 20000;

    // clock, reset and register port
    logic              ref_clk_i;
    logic              rst_n_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i;
    logic              reg_wr_i;
    logic              reg_rd_i;
    logic [DATA_W-1:0] reg_rdata_o;
    // straps and link state
    logic              p2_bp_strap, p2_pause_strap, p2_man_strap;
    logic              p0_bp_strap, p0_pause_strap, p0_man_strap;
    logic              ext_mac_mode_i;
    logic [1:0]        aneg_en_i, half_duplex_i, neg_pause_rx_i, neg_pause_tx_i;
    logic [1:0]        pause_rx_on_o, pause_tx_on_o, backpressure_on_o;
    // reference copy of the writable bits, index 0 port 0, index 1 port 2
    logic [1:0]        m_bp, m_rx, m_tx, m_man;
    logic              m_ext;
    logic [31:0]       seed;
    logic [31:0]       expq[$];
    logic              rd_taken;
    int                miscompares;
    int                compares;
    int                cycles;
    logic [ADDR_W-1:0] addrs[4];

    pfc_regs dut (
        .ref_clk_i                  (ref_clk_i),
        .rst_n_i                    (rst_n_i),
        .reg_addr_i                 (reg_addr_i),
        .reg_wdata_i                (reg_wdata_i),
        .reg_wr_i                   (reg_wr_i),
        .reg_rd_i                   (reg_rd_i),
        .reg_rdata_o                (reg_rdata_o),
        .p2_backpressure_pinstrap_i (p2_bp_strap),
        .p2_pause_pinstrap_i        (p2_pause_strap),
        .p2_manual_sel_pinstrap_i   (p2_man_strap),
        .p0_backpressure_pinstrap_i (p0_bp_strap),
        .p0_pause_pinstrap_i        (p0_pause_strap),
        .p0_manual_sel_pinstrap_i   (p0_man_strap),
        .ext_mac_mode_i             (ext_mac_mode_i),
        .aneg_en_i                  (aneg_en_i),
        .half_duplex_i              (half_duplex_i),
        .neg_pause_rx_i             (neg_pause_rx_i),
        .neg_pause_tx_i             (neg_pause_tx_i),
        .pause_rx_on_o              (pause_rx_on_o),
        .pause_tx_on_o              (pause_tx_on_o),
        .backpressure_on_o          (backpressure_on_o)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // setting in force: written bit when manual or no negotiation, off in half duplex
    function automatic logic lv(input int s, input logic wbit, input logic nbit);
        logic use_w;
        use_w = m_man[s] | ~aneg_en_i[s];
        return ~half_duplex_i[s] & (use_w ? wbit : nbit);
    endfunction

    function automatic logic [31:0] exp_word(input int s);
        return {25'h0, m_bp[s], half_duplex_i[s], lv(s, m_rx[s], neg_pause_rx_i[s]),
                lv(s, m_tx[s], neg_pause_tx_i[s]), m_rx[s], m_tx[s], m_man[s]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic drive_link(input logic [7:0] v);
        aneg_en_i      <= v[1:0];
        half_duplex_i  <= v[3:2];
        neg_pause_rx_i <= v[5:4];
        neg_pause_tx_i <= v[7:6];
    endtask

    // ------------------------------------------------------------
    // register port master
    // ------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
        if (a == OFF_P2_FC || a == OFF_P0_FC) begin
            int s;
            s = (a == OFF_P2_FC) ? 1 : 0;
            m_bp[s]  = d[6];
            m_rx[s]  = d[2];
            m_tx[s]  = d[1];
            m_man[s] = (s == 0 && m_ext) ? 1'b1 : d[0];
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        expq.push_back(e);
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
    endtask

    task automatic check_live();
        check({30'h0, pause_rx_on_o}, {30'h0, lv(1, m_rx[1], neg_pause_rx_i[1]),
              lv(0, m_rx[0], neg_pause_rx_i[0])});
        check({30'h0, pause_tx_on_o}, {30'h0, lv(1, m_tx[1], neg_pause_tx_i[1]),
              lv(0, m_tx[0], neg_pause_tx_i[0])});
        check({30'h0, backpressure_on_o}, {30'h0, m_bp & half_duplex_i});
    endtask

    // reset with random straps; straps flip after release and must be ignored
    task automatic do_reset(input logic ext);
        logic [31:0] r;
        r = xs();
        @(posedge ref_clk_i);
        rst_n_i        <= 1'b0;
        ext_mac_mode_i <= ext;
        {p2_man_strap, p2_pause_strap, p2_bp_strap} <= r[5:3];
        {p0_man_strap, p0_pause_strap, p0_bp_strap} <= r[2:0];
        drive_link(r[15:8]);
        repeat (5) @(posedge ref_clk_i);
        rst_n_i        <= 1'b1;
        {p2_man_strap, p2_pause_strap, p2_bp_strap} <= ~r[5:3];
        {p0_man_strap, p0_pause_strap, p0_bp_strap} <= ~r[2:0];
        ext_mac_mode_i <= ~ext;
        m_ext = ext;
        m_bp  = {r[3], r[0]};
        m_rx  = {r[4], r[1]};
        m_tx  = {r[4], r[1]};
        m_man = {r[5], r[2] | ext};
        @(posedge ref_clk_i);
        #1 check_live();
        rd(OFF_P2_FC, exp_word(1));
        rd(OFF_P0_FC, exp_word(0));
    endtask

    // new link state, random write (mapped or not), then readback
    task automatic round();
        logic [31:0] r;
        logic [31:0] d;
        r = xs();
        d = xs();
        @(posedge ref_clk_i);
        drive_link(r[15:8]);
        wr(addrs[r[1:0]], d);
        repeat (3) @(posedge ref_clk_i);
        #1 check_live();
        rd(OFF_P2_FC, exp_word(1));
        rd(OFF_P0_FC, exp_word(0));
        rd(addrs[{1'b1, r[2]}], 32'h0);
    endtask

    // ------------------------------------------------------------
    // read data watcher: oldest note against what appears
    // ------------------------------------------------------------
    initial begin
        forever begin
            @(posedge ref_clk_i);
            rd_taken = reg_rd_i;
            #1;
            if (rd_taken && expq.size() == 0) begin
                check(reg_rdata_o, 32'hffff_ffff);
            end else if (rd_taken) begin
                check(reg_rdata_o, expq.pop_front());
            end else begin
                check(reg_rdata_o, RD_IDLE);
            end
        end
    end

    // clock and hang guard
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed           = 32'd80092;
        rst_n_i        = 1'b0;
        reg_addr_i     = 12'h000;
        reg_wdata_i    = 32'h0000_0000;
        reg_wr_i       = 1'b0;
        reg_rd_i       = 1'b0;
        {p2_bp_strap, p2_pause_strap, p2_man_strap} = 3'h0;
        {p0_bp_strap, p0_pause_strap, p0_man_strap} = 3'h0;
        ext_mac_mode_i = 1'b0;
        aneg_en_i      = 2'h0;
        half_duplex_i  = 2'h0;
        neg_pause_rx_i = 2'h0;
        neg_pause_tx_i = 2'h0;
        miscompares    = 0;
        compares       = 0;
        cycles         = 0;
        addrs          = '{OFF_P2_FC, OFF_P0_FC, 12'h1ac, 12'h1a0};
        do_reset(1'b0);
        repeat (40) round();
        do_reset(1'b1);
        repeat (40) round();
        repeat (3) @(posedge ref_clk_i);
        stop_test();
    end

endmodule

`default_nettype wire

// [design/pfc_pkg.sv]
package pfc_pkg;

    // ------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_P2_FC = 12'h1a4;
    localparam logic [ADDR_W-1:0] OFF_P0_FC = 12'h1a8;

    // ------------------------------------------------------------
    // field positions, same layout in both registers
    // ------------------------------------------------------------
    localparam int unsigned BIT_BP  = 6;  // backpressure enable
    localparam int unsigned BIT_DUP = 5;  // live duplex, 1 = half
    localparam int unsigned BIT_LRX = 4;  // live pause receive
    localparam int unsigned BIT_LTX = 3;  // live pause transmit
    localparam int unsigned BIT_RX  = 2;  // pause receive enable
    localparam int unsigned BIT_TX  = 1;  // pause transmit enable
    localparam int unsigned BIT_MAN = 0;  // manual select
    localparam int unsigned RSV_LO  = 7;  // lowest reserved bit

    // ------------------------------------------------------------
    // port slots and idle read value
    // ------------------------------------------------------------
    localparam int unsigned N_PORT  = 2;
    localparam int unsigned SLOT_P0 = 0;
    localparam int unsigned SLOT_P2 = 1;
    localparam logic [DATA_W-1:0] RD_IDLE = 32'h0000_0000;

endpackage

// [design/pfc_port_resolve.sv]
`timescale 1ns/1ps
`default_nettype none

module pfc_port_resolve (
    // register settings
    input  wire logic man_sel_i,
    input  wire logic rx_en_i,
    input  wire logic tx_en_i,
    input  wire logic bp_en_i,
    // link state
    input  wire logic aneg_en_i,
    input  wire logic half_i,
    input  wire logic neg_rx_i,
    input  wire logic neg_tx_i,
    // settings in force
    output logic      live_rx_o,
    output logic      live_tx_o,
    output logic      bp_act_o
);
    import pfc_pkg::*;

    logic use_reg;

    // written bits rule when manual or negotiation is off
    always_comb begin
        use_reg   = man_sel_i | ~aneg_en_i;
        live_rx_o = ~half_i & (use_reg ? rx_en_i : neg_rx_i);
        live_tx_o = ~half_i & (use_reg ? tx_en_i : neg_tx_i);
        bp_act_o  = half_i & bp_en_i;
    end

endmodule
`default_nettype wire

// [design/pfc_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module pfc_regs (
    // clock and reset
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_n_i,
    // register port
    input  wire logic [pfc_pkg::ADDR_W-1:0]   reg_addr_i,
    input  wire logic [pfc_pkg::DATA_W-1:0]   reg_wdata_i,
    input  wire logic                         reg_wr_i,
    input  wire logic                         reg_rd_i,
    output logic      [pfc_pkg::DATA_W-1:0]   reg_rdata_o,
    // configuration straps
    input  wire logic                         p2_backpressure_pinstrap_i,
    input  wire logic                         p2_pause_pinstrap_i,
    input  wire logic                         p2_manual_sel_pinstrap_i,
    input  wire logic                         p0_backpressure_pinstrap_i,
    input  wire logic                         p0_pause_pinstrap_i,
    input  wire logic                         p0_manual_sel_pinstrap_i,
    input  wire logic                         ext_mac_mode_i,
    // link state, bit 0 port 0, bit 1 port 2
    input  wire logic [pfc_pkg::N_PORT-1:0]   aneg_en_i,
    input  wire logic [pfc_pkg::N_PORT-1:0]   half_duplex_i,
    input  wire logic [pfc_pkg::N_PORT-1:0]   neg_pause_rx_i,
    input  wire logic [pfc_pkg::N_PORT-1:0]   neg_pause_tx_i,
    // settings in force, to the port macs
    output logic      [pfc_pkg::N_PORT-1:0]   pause_rx_on_o,
    output logic      [pfc_pkg::N_PORT-1:0]   pause_tx_on_o,
    output logic      [pfc_pkg::N_PORT-1:0]   backpressure_on_o
);
    import pfc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [N_PORT-1:0] bp;    // backpressure enable
        logic [N_PORT-1:0] rx;    // pause receive enable
        logic [N_PORT-1:0] tx;    // pause transmit enable
        logic [N_PORT-1:0] man;   // manual select
        logic [N_PORT-1:0] half;  // live duplex
        logic [N_PORT-1:0] lrx;   // live pause receive
        logic [N_PORT-1:0] ltx;   // live pause transmit
        logic [N_PORT-1:0] bpa;   // backpressure in force
        logic [DATA_W-1:0] rdata; // read answer
    } pfc_regs_s;

    pfc_regs_s st_ff;
    pfc_regs_s nxt_st;

    // captured straps
    logic [N_PORT-1:0] lat_bp;
    logic [N_PORT-1:0] lat_pause;
    logic [N_PORT-1:0] lat_man;
    logic              lat_ext;

    // resolver inputs and results
    logic [N_PORT-1:0] cfg_bp;
    logic [N_PORT-1:0] cfg_rx;
    logic [N_PORT-1:0] cfg_tx;
    logic [N_PORT-1:0] cfg_man;
    logic [N_PORT-1:0] res_rx;
    logic [N_PORT-1:0] res_tx;
    logic [N_PORT-1:0] res_bpa;

    // decoded strobes
    logic [N_PORT-1:0] wr_hit;
    logic [N_PORT-1:0] rd_hit;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    // one-hot slot select for an address, zero when unmapped
    function automatic logic [N_PORT-1:0] pfc_hit(input logic [ADDR_W-1:0] a);
        logic [N_PORT-1:0] h;
        h          = '0;
        h[SLOT_P2] = (a == OFF_P2_FC);
        h[SLOT_P0] = (a == OFF_P0_FC);
        return h;
    endfunction

    // register image of one port
    function automatic logic [DATA_W-1:0] pfc_word(input pfc_regs_s s,
                                                   input int unsigned p);
        logic [DATA_W-1:0] w;
        w          = RD_IDLE;
        w[BIT_BP]  = s.bp[p];
        w[BIT_DUP] = s.half[p];
        w[BIT_LRX] = s.lrx[p];
        w[BIT_LTX] = s.ltx[p];
        w[BIT_RX]  = s.rx[p];
        w[BIT_TX]  = s.tx[p];
        w[BIT_MAN] = s.man[p];
        return w;
    endfunction

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    pfc_strap_latch #(
        .N             (N_PORT)
    ) u_strap (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .bp_strap_i    ({p2_backpressure_pinstrap_i, p0_backpressure_pinstrap_i}),
        .pause_strap_i ({p2_pause_pinstrap_i, p0_pause_pinstrap_i}),
        .man_strap_i   ({p2_manual_sel_pinstrap_i, p0_manual_sel_pinstrap_i}),
        .ext_mac_i     (ext_mac_mode_i),
        .bp_o          (lat_bp),
        .pause_o       (lat_pause),
        .man_o         (lat_man),
        .ext_mac_o     (lat_ext)
    );

    // ------------------------------------------------------------
    // per-port flow control resolution
    // ------------------------------------------------------------
    // in reset the resolver sees the straps, so status resets from them
    always_comb begin
        cfg_bp  = rst_n_i ? st_ff.bp  : lat_bp;
        cfg_rx  = rst_n_i ? st_ff.rx  : lat_pause;
        cfg_tx  = rst_n_i ? st_ff.tx  : lat_pause;
        cfg_man = rst_n_i ? st_ff.man : lat_man;
        if (lat_ext) begin
            cfg_man[SLOT_P0] = 1'b1;
        end
    end

    for (genvar g = 0; g < N_PORT; g++) begin : g_port
        pfc_port_resolve u_res (
            .man_sel_i (cfg_man[g]),
            .rx_en_i   (cfg_rx[g]),
            .tx_en_i   (cfg_tx[g]),
            .bp_en_i   (cfg_bp[g]),
            .aneg_en_i (aneg_en_i[g]),
            .half_i    (half_duplex_i[g]),
            .neg_rx_i  (neg_pause_rx_i[g]),
            .neg_tx_i  (neg_pause_tx_i[g]),
            .live_rx_o (res_rx[g]),
            .live_tx_o (res_tx[g]),
            .bp_act_o  (res_bpa[g])
        );
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // writes touch only local bits; no path reaches phy advertisement
    always_comb begin
        nxt_st       = st_ff;
        wr_hit       = pfc_hit(reg_addr_i) & {N_PORT{reg_wr_i}};
        rd_hit       = pfc_hit(reg_addr_i) & {N_PORT{reg_rd_i}};
        nxt_st.rdata = RD_IDLE;
        for (int unsigned p = 0; p < N_PORT; p++) begin
            if (wr_hit[p]) begin
                nxt_st.bp[p]  = reg_wdata_i[BIT_BP];
                nxt_st.rx[p]  = reg_wdata_i[BIT_RX];
                nxt_st.tx[p]  = reg_wdata_i[BIT_TX];
                nxt_st.man[p] = reg_wdata_i[BIT_MAN];
            end
            if (rd_hit[p]) begin
                nxt_st.rdata = pfc_word(st_ff, p);
            end
        end
        // live status follows the resolved settings
        nxt_st.half = half_duplex_i;
        nxt_st.lrx  = res_rx;
        nxt_st.ltx  = res_tx;
        nxt_st.bpa  = res_bpa;
        if (!rst_n_i) begin
            nxt_st.bp    = lat_bp;
            nxt_st.rx    = lat_pause;
            nxt_st.tx    = lat_pause;
            nxt_st.man   = lat_man;
            nxt_st.rdata = RD_IDLE;
        end
        // external mac mode pins the port 0 manual bit
        if (lat_ext) begin
            nxt_st.man[SLOT_P0] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o       = st_ff.rdata;
    assign pause_rx_on_o     = st_ff.lrx;
    assign pause_tx_on_o     = st_ff.ltx;
    assign backpressure_on_o = st_ff.bpa;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_rd_p2;
        reg_rd_i && (reg_addr_i == OFF_P2_FC);
    endsequence

    sequence s_wr_p0;
        reg_wr_i && (reg_addr_i == OFF_P0_FC);
    endsequence

    sequence s_rd_p0;
        reg_rd_i && (reg_addr_i == OFF_P0_FC);
    endsequence

    sequence s_wr_p2;
        reg_wr_i && (reg_addr_i == OFF_P2_FC);
    endsequence

    sequence s_rst_two;
        !rst_n_i ##1 !rst_n_i ##1 rst_n_i;
    endsequence

    // read data of port 2 one cycle later, then back to idle
    AST_RD_P2: assert property (
        s_rd_p2 |=> (reg_rdata_o[BIT_BP] == $past(st_ff.bp[SLOT_P2]))
            && (reg_rdata_o[BIT_MAN] == $past(st_ff.man[SLOT_P2]))
            && (reg_rdata_o[BIT_LRX] == $past(st_ff.lrx[SLOT_P2]))
            && (reg_rdata_o[BIT_LTX] == $past(st_ff.ltx[SLOT_P2]))
            ##1 ($past(reg_rd_i) || reg_rdata_o == RD_IDLE)
    ) else $error("port 2 read data wrong");

    // port 0 write lands in its own register only
    AST_WR_P0: assert property (
        s_wr_p0 |=> (st_ff.tx[SLOT_P0] == $past(reg_wdata_i[BIT_TX]))
            && (st_ff.rx[SLOT_P0] == $past(reg_wdata_i[BIT_RX]))
            && $stable(st_ff.tx[SLOT_P2])
    ) else $error("port 0 write not stored");

    // backpressure only in half-duplex and when enabled
    AST_BP_ACT: assert property (
        $past(rst_n_i) |->
            backpressure_on_o == $past(st_ff.bp & half_duplex_i)
    ) else $error("backpressure output wrong");

    // live duplex tracks the port a cycle later
    AST_DUP: assert property (
        $past(rst_n_i) |-> st_ff.half == $past(half_duplex_i)
    ) else $error("live duplex wrong");

    // negotiated result rules when manual clear and negotiation on
    AST_NEG_RX: assert property (
        (!st_ff.man[SLOT_P2] && aneg_en_i[SLOT_P2] && !half_duplex_i[SLOT_P2])
            |=> pause_rx_on_o[SLOT_P2] == $past(neg_pause_rx_i[SLOT_P2])
    ) else $error("negotiated pause receive not applied");

    // manual select makes the written transmit bit rule
    AST_MAN_TX: assert property (
        (st_ff.man[SLOT_P2] && !half_duplex_i[SLOT_P2])
            |=> pause_tx_on_o[SLOT_P2] == $past(st_ff.tx[SLOT_P2])
    ) else $error("manual pause transmit not applied");

    // no pause frames in half-duplex
    AST_HALF: assert property (
        half_duplex_i[SLOT_P2]
            |=> !pause_rx_on_o[SLOT_P2] && !pause_tx_on_o[SLOT_P2]
    ) else $error("pause enabled in half-duplex");

    // port 0 with virtual negotiation off uses written bits
    AST_P0_VNEG: assert property (
        (!aneg_en_i[SLOT_P0] && !half_duplex_i[SLOT_P0])
            |=> pause_rx_on_o[SLOT_P0] == $past(st_ff.rx[SLOT_P0])
    ) else $error("port 0 written pause receive ignored");

    // external mac mode keeps port 0 manual select high
    AST_EXT_MAN: assert property (
        (lat_ext && reg_wr_i && (reg_addr_i == OFF_P0_FC) && !reg_wdata_i[BIT_MAN])
            |=> st_ff.man[SLOT_P0]
    ) else $error("port 0 manual select cleared");

    // reserved field always reads zero
    AST_RSV: assert property (
        reg_rd_i |=> reg_rdata_o[DATA_W-1:RSV_LO] == '0
    ) else $error("reserved bits not zero");

    // unmapped reads answer zero
    AST_UNMAP: assert property (
        (reg_rd_i && (pfc_hit(reg_addr_i) == '0)) |=> reg_rdata_o == RD_IDLE
    ) else $error("unmapped read not zero");

    // read data of port 0 comes from its own slot
    AST_RD_P0: assert property (
        s_rd_p0 |=> (reg_rdata_o[BIT_RX] == $past(st_ff.rx[SLOT_P0]))
            && (reg_rdata_o[BIT_TX] == $past(st_ff.tx[SLOT_P0]))
            && (reg_rdata_o[BIT_DUP] == $past(st_ff.half[SLOT_P0]))
    ) else $error("port 0 read data wrong");

    // port 2 write lands in its own register only
    AST_WR_P2: assert property (
        s_wr_p2 |=> (st_ff.bp[SLOT_P2] == $past(reg_wdata_i[BIT_BP]))
            && (st_ff.man[SLOT_P2] == $past(reg_wdata_i[BIT_MAN]))
            && $stable(st_ff.bp[SLOT_P0])
    ) else $error("port 2 write not stored");

    // negotiated transmit result rules when manual clear and negotiation on
    AST_NEG_TX: assert property (
        (!st_ff.man[SLOT_P2] && aneg_en_i[SLOT_P2] && !half_duplex_i[SLOT_P2])
            |=> pause_tx_on_o[SLOT_P2] == $past(neg_pause_tx_i[SLOT_P2])
    ) else $error("negotiated pause transmit not applied");

    // port 0 with virtual negotiation off uses the written transmit bit
    AST_P0_VNEG_TX: assert property (
        (!aneg_en_i[SLOT_P0] && !half_duplex_i[SLOT_P0])
            |=> pause_tx_on_o[SLOT_P0] == $past(st_ff.tx[SLOT_P0])
    ) else $error("port 0 written pause transmit ignored");

    // external mac mode reads back port 0 manual select as set
    AST_EXT_RD: assert property (
        (lat_ext && reg_rd_i && (reg_addr_i == OFF_P0_FC)) |=> reg_rdata_o[BIT_MAN]
    ) else $error("port 0 manual select reads clear");

    // live receive status bit matches the port 0 output
    AST_LIVE_RX: assert property (
        s_rd_p0 |=> reg_rdata_o[BIT_LRX] == $past(pause_rx_on_o[SLOT_P0])
    ) else $error("live pause receive bit wrong");

    // live transmit status bit matches the port 2 output
    AST_LIVE_TX: assert property (
        s_rd_p2 |=> reg_rdata_o[BIT_LTX] == $past(pause_tx_on_o[SLOT_P2])
    ) else $error("live pause transmit bit wrong");

    // two reset edges load the backpressure straps
    AST_RST_STRAP: assert property (
        @(posedge ref_clk_i) disable iff (1'b0)
        s_rst_two |-> st_ff.bp == $past({p2_backpressure_pinstrap_i,
                                          p0_backpressure_pinstrap_i}, 2)
    ) else $error("backpressure reset value not from strap");

endmodule
`default_nettype wire

// [design/pfc_strap_latch.sv]
`timescale 1ns/1ps
`default_nettype none

module pfc_strap_latch #(
    parameter int unsigned N = pfc_pkg::N_PORT
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    // raw strap levels
    input  wire logic [N-1:0] bp_strap_i,
    input  wire logic [N-1:0] pause_strap_i,
    input  wire logic [N-1:0] man_strap_i,
    input  wire logic         ext_mac_i,
    // captured strap levels
    output logic      [N-1:0] bp_o,
    output logic      [N-1:0] pause_o,
    output logic      [N-1:0] man_o,
    output logic              ext_mac_o
);
    import pfc_pkg::*;

    typedef struct packed {
        logic [N-1:0] bp;
        logic [N-1:0] pause;
        logic [N-1:0] man;
        logic         ext;
    } pfc_latch_s;

    pfc_latch_s st_ff;
    pfc_latch_s nxt_st;

    if (N != N_PORT) begin : g_bad_n
        $error("pfc_strap_latch: N must equal the port count");
    end

    // straps are followed while reset is low, then frozen
    always_comb begin
        nxt_st = st_ff;
        if (!rst_n_i) begin
            nxt_st.bp    = bp_strap_i;
            nxt_st.pause = pause_strap_i;
            nxt_st.man   = man_strap_i;
            nxt_st.ext   = ext_mac_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        st_ff <= nxt_st;
    end

    assign bp_o      = st_ff.bp;
    assign pause_o   = st_ff.pause;
    assign man_o     = st_ff.man;
    assign ext_mac_o = st_ff.ext;

endmodule
`default_nettype wire
